// ===== pkg/asc_pkg.sv
`default_nettype none
package asc_pkg;
    // per-channel register bases; channel number is added (0x00..0x09)
    localparam logic [7:0]  A_CTLA   = 8'h00;
    localparam logic [7:0]  A_CTLB   = 8'h02;
    localparam logic [7:0]  A_STAT   = 8'h04;
    localparam logic [7:0]  A_TDR    = 8'h06;
    localparam logic [7:0]  A_RDR    = 8'h08;
    // control register a
    localparam int          CA_MPE   = 7;
    localparam int          CA_RE    = 6;
    localparam int          CA_TE    = 5;
    localparam int          CA_RTS   = 4;
    localparam int          CA_EFR   = 3;
    localparam int          CA_DATA_WIDTH_SELECT  = 2;
    localparam int          CA_MOD1  = 1;
    localparam int          CA_MOD0  = 0;
    // control register b
    localparam int          CB_MPBT  = 7;
    localparam int          CB_MP    = 6;
    localparam int          CB_PS    = 5;
    localparam int          CB_PEO   = 4;
    localparam int          CB_DR    = 3;
    localparam int          CB_SS    = 0;
    // channel_status
    localparam int          ST_RX_FULL_FLAG  = 7;
    localparam int          ST_OVRN  = 6;
    localparam int          ST_PE    = 5;
    localparam int          ST_FE    = 4;
    localparam int          ST_RIE   = 3;
    localparam int          ST_DCD   = 2;
    localparam int          ST_TX_EMPTY_FLAG  = 1;
    localparam int          ST_TIE   = 0;
    localparam logic [7:0]  CTLA_RST = 8'h10;
    localparam logic [7:0]  CTLB_RST = 8'h00;
    localparam logic [1:0]  TX_EMPTY_FLAG_RST = 2'h3;
    localparam logic [2:0]  SS_EXT   = 3'h7;
    localparam logic [10:0] PS_LO    = 11'h00a;
    localparam logic [10:0] PS_HI    = 11'h01e;
    localparam logic [6:0]  OS_LO    = 7'h10;
    localparam logic [6:0]  OS_HI    = 7'h40;
    localparam logic [3:0]  FR_MAX   = 4'hd;
    // synchroniser reset = idle pins: ext low, cts not clear, rx high, no carrier
    localparam logic [6:0]  SYNC_RST = 7'h1e;
    // standard rates result when core_clk runs at the reference rate
    localparam int          REF_CLK_HZ = 32'h008c_a000;
    localparam int          XTAL_HZ    = 32'h0119_4000;
endpackage : asc_pkg
`default_nettype wire

// ===== verilog/asc_pair.sv
// Summary of operation
// - two independent full-duplex channels, each with own internal or external baud source
// - multiprocessor mode adds one extra bit after the data and any parity bit
// - filtering receiver drops characters whose extra bit is clear
// - channel 1 has no request-to-send output and no carrier input
// - clear-to-send high forces the transmit-empty flag to read inactive
// - transmitter keeps shifting loaded characters while clear-to-send is high
// - interrupt sources: receive full, transmit empty, receive error, carrier (channel 0)
// - interrupt requests are levels held until the cause is removed
// - carrier source masked by receive interrupt enable: requests whenever it is set and the carrier bit is set
// - carrier bit follows pin; after falling, clears only after status read
// - channel 0 receiver held reset while carrier input is high
// - transmit interrupt enable set requests interrupt while transmit-empty reads set
// - each channel has a status register with state and interrupt enables
// - baud dividers give standard rates from the 9.216 MHz reference clock
// - reading receive data clears receive-full
// - control-a write with error reset bit zero clears all error flags
// - dropped characters leave error flags and receive-full unchanged
// - data width select: 0 gives 7 data bits, 1 gives 8
`default_nettype none
module asc_pair (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic [1:0] rxd,
    input  wire logic [1:0] cts_n,
    input  wire logic [1:0] ext_clk,
    input  wire logic       carrier_detect_in,
    output logic      [1:0] txd,
    output logic            rts_n,
    output logic      [1:0] irq
);
    logic [6:0]  s1_q, s2_q;
    logic [1:0]  ext_s, cts_s, rx_s, ext_p_q;
    logic        dcd_s, dcd_q, dcd_d;
    logic [7:0]  ctla_q [2], ctla_d [2], ctlb_q [2], ctlb_d [2];
    logic [7:0]  tdr_q [2], tdr_d [2], rdr_q [2], rdr_d [2];
    logic [10:0] bcnt_q [2], bcnt_d [2];
    logic [12:0] txsh_q [2], txsh_d [2], rxsh_q [2], rxsh_d [2];
    logic [3:0]  txn_q [2], txn_d [2], rxn_q [2], rxn_d [2];
    logic [6:0]  txs_q [2], txs_d [2], rxs_q [2], rxs_d [2];
    logic [1:0]  tx_empty_flag_q, tx_empty_flag_d, rx_full_flag_q, rx_full_flag_d, ovrn_q, ovrn_d, pe_q, pe_d;
    logic [1:0]  fe_q, fe_d, mpb_q, mpb_d, rie_q, rie_d, tie_q, tie_d;
    logic [1:0]  rxon_q, rxon_d, txd_q, txd_d, irq_q, irq_d;
    logic [1:0]  tick, load, done, drop, tx_empty_flag_v;
    logic [7:0]  rdata_q, rdata_d, r8;
    logic        rts_q;
    logic [12:0] nsh;
    logic [10:0] dec, lim;
    logic [6:0]  os;
    logic [3:0]  len;
    logic        rxrst;

    assign {ext_s, cts_s, rx_s, dcd_s} = s2_q;
    assign io_rdata = rdata_q;
    assign txd      = txd_q;
    assign irq      = irq_q;
    assign rts_n    = rts_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input int c);
        return a == (b | 8'(c));
    endfunction : hit

    // start + data + parity + address bit + stop bits
    function automatic logic [3:0] flen(input logic [7:0] a, input logic [7:0] b);
        return 4'h2 + (a[asc_pkg::CA_DATA_WIDTH_SELECT] ? 4'h8 : 4'h7) + {3'h0, a[asc_pkg::CA_MOD1]}
            + {3'h0, b[asc_pkg::CB_MP]} + {3'h0, a[asc_pkg::CA_MOD0]};
    endfunction : flen

    function automatic logic [12:0] tx_frame(input logic [7:0] d, input logic [7:0] a,
                                             input logic [7:0] b);
        logic [12:0] f;
        logic        par;
        int          p;
        f   = '1;
        f[0] = 1'b0;
        p   = 1;
        par = b[asc_pkg::CB_PEO];
        for (int k = 0; k < 8; k++)
        begin
            if (k < 7 || a[asc_pkg::CA_DATA_WIDTH_SELECT])
            begin
                f[p] = d[k];
                par  = par ^ d[k];
                p++;
            end
        end
        if (a[asc_pkg::CA_MOD1])
        begin
            f[p] = par;
            p++;
        end
        if (b[asc_pkg::CB_MP])
            f[p] = b[asc_pkg::CB_MPBT];
        return f;
    endfunction : tx_frame

    // returns {fe, pe, address bit, data}
    function automatic logic [10:0] rx_decode(input logic [12:0] s, input logic [7:0] a,
                                              input logic [7:0] b);
        logic [12:0] f;
        logic [7:0]  d;
        logic        pe, mb;
        int          p;
        f  = s >> (asc_pkg::FR_MAX - flen(a, b));
        d  = 8'h00;
        pe = b[asc_pkg::CB_PEO];
        mb = 1'b0;
        p  = 1;
        for (int k = 0; k < 8; k++)
        begin
            if (k < 7 || a[asc_pkg::CA_DATA_WIDTH_SELECT])
            begin
                d[k] = f[p];
                pe   = pe ^ f[p];
                p++;
            end
        end
        if (a[asc_pkg::CA_MOD1])
        begin
            pe = pe ^ f[p];
            p++;
        end
        else
            pe = 1'b0;
        if (b[asc_pkg::CB_MP])
        begin
            mb = f[p];
            p++;
        end
        return {~f[p] | (a[asc_pkg::CA_MOD0] & ~f[p+1]), pe, mb, d};
    endfunction : rx_decode

    // pins cross into core_clk through two flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= asc_pkg::SYNC_RST;
            s2_q <= asc_pkg::SYNC_RST;
        end
        else
        begin
            s1_q <= {ext_clk, cts_n, rxd, carrier_detect_in};
            s2_q <= s1_q;
        end
    end

    always_comb
    begin
        rdata_d = 8'h00;
        r8      = 8'h00;
        nsh     = '0;
        dec     = '0;
        lim     = '0;
        os      = '0;
        len     = '0;
        rxrst   = 1'b0;
        {tick, load, done, drop, tx_empty_flag_v, irq_d, txd_d} = '0;
        dcd_d   = dcd_s | (dcd_q & ~(io_rd & hit(io_addr, asc_pkg::A_STAT, 0)));
        ctla_d = ctla_q;
        ctlb_d = ctlb_q;
        tdr_d  = tdr_q;
        rdr_d  = rdr_q;
        bcnt_d = bcnt_q;
        txsh_d = txsh_q;
        rxsh_d = rxsh_q;
        txn_d  = txn_q;
        rxn_d  = rxn_q;
        txs_d  = txs_q;
        rxs_d  = rxs_q;
        {tx_empty_flag_d, rx_full_flag_d, ovrn_d} = {tx_empty_flag_q, rx_full_flag_q, ovrn_q};
        {pe_d, fe_d, mpb_d, rie_d, tie_d, rxon_d} = {pe_q, fe_q, mpb_q, rie_q, tie_q, rxon_q};
        for (int c = 0; c < 2; c++)
        begin
            os  = ctlb_q[c][asc_pkg::CB_DR] ? asc_pkg::OS_HI : asc_pkg::OS_LO;
            lim = (ctlb_q[c][asc_pkg::CB_PS] ? asc_pkg::PS_HI : asc_pkg::PS_LO)
                << ctlb_q[c][asc_pkg::CB_SS +: 3];
            len = flen(ctla_q[c], ctlb_q[c]);
            // one tick per oversample; ext clock edge when selected
            if (ctlb_q[c][asc_pkg::CB_SS +: 3] == asc_pkg::SS_EXT)
            begin
                tick[c]   = ext_s[c] & ~ext_p_q[c];
                bcnt_d[c] = '0;
            end
            else
            begin
                tick[c]   = bcnt_q[c] == lim - 11'h001;
                bcnt_d[c] = tick[c] ? 11'h000 : bcnt_q[c] + 11'h001;
            end
            tx_empty_flag_v[c] = tx_empty_flag_q[c] & ~cts_s[c];
            irq_d[c]  = (rie_q[c] & (rx_full_flag_q[c] | ovrn_q[c] | pe_q[c] | fe_q[c]
                       | (c == 0 && dcd_q))) | (tie_q[c] & tx_empty_flag_v[c]);
            // transmitter ignores clear-to-send on purpose
            load[c] = ctla_q[c][asc_pkg::CA_TE] & ~tx_empty_flag_q[c] & (txn_q[c] == 4'h0);
            if (load[c])
            begin
                txsh_d[c] = tx_frame(tdr_q[c], ctla_q[c], ctlb_q[c]);
                txn_d[c]  = len;
                txs_d[c]  = '0;
                tx_empty_flag_d[c] = 1'b1;
            end
            else if (txn_q[c] != 4'h0 && tick[c])
            begin
                txs_d[c] = txs_q[c] + 7'h01;
                if (txs_q[c] == os - 7'h01)
                begin
                    txs_d[c]  = '0;
                    txsh_d[c] = {1'b1, txsh_q[c][12:1]};
                    txn_d[c]  = txn_q[c] - 4'h1;
                end
            end
            if (!ctla_q[c][asc_pkg::CA_TE])
                txn_d[c] = '0;
            txd_d[c] = (txn_q[c] == 4'h0) | txsh_q[c][0];
            // receiver: sample mid-bit, first sample checks the start bit
            rxrst   = ~ctla_q[c][asc_pkg::CA_RE] | (c == 0 && dcd_s);
            nsh     = {rx_s[c], rxsh_q[c][12:1]};
            dec     = rx_decode(nsh, ctla_q[c], ctlb_q[c]);
            done[c] = ~rxrst & rxon_q[c] & tick[c] & (rxs_q[c] == (os >> 1))
                    & (rxn_q[c] == 4'h1);
            drop[c] = done[c] & ctla_q[c][asc_pkg::CA_MPE] & ctlb_q[c][asc_pkg::CB_MP]
                    & ~dec[8];
            if (!rxon_q[c])
            begin
                if (tick[c] && !rx_s[c])
                begin
                    rxon_d[c] = 1'b1;
                    rxs_d[c]  = '0;
                    rxn_d[c]  = len;
                end
            end
            else if (tick[c])
            begin
                rxs_d[c] = (rxs_q[c] == os - 7'h01) ? 7'h00 : rxs_q[c] + 7'h01;
                if (rxs_q[c] == (os >> 1))
                begin
                    rxsh_d[c] = nsh;
                    rxn_d[c]  = rxn_q[c] - 4'h1;
                    if ((rxn_q[c] == len && rx_s[c]) || rxn_q[c] == 4'h1)
                        rxon_d[c] = 1'b0;
                end
            end
            if (rxrst)
                rxon_d[c] = 1'b0;
            if ((io_rd && hit(io_addr, asc_pkg::A_RDR, c)) || (c == 0 && dcd_s))
                rx_full_flag_d[c] = 1'b0;
            if (io_wr && hit(io_addr, asc_pkg::A_CTLA, c) && !io_wdata[asc_pkg::CA_EFR])
            begin
                ovrn_d[c] = 1'b0;
                pe_d[c]   = 1'b0;
                fe_d[c]   = 1'b0;
            end
            // a completed character beats a clear in the same cycle
            if (done[c] && !drop[c])
            begin
                mpb_d[c] = dec[8];
                if (rx_full_flag_q[c] && rx_full_flag_d[c])
                    ovrn_d[c] = 1'b1;
                else
                begin
                    rdr_d[c]  = dec[7:0];
                    rx_full_flag_d[c] = 1'b1;
                    pe_d[c]   = pe_d[c] | dec[9];
                    fe_d[c]   = fe_d[c] | dec[10];
                end
            end
            if (io_wr)
            begin
                if (hit(io_addr, asc_pkg::A_CTLA, c))
                    ctla_d[c] = io_wdata;
                if (hit(io_addr, asc_pkg::A_CTLB, c))
                    ctlb_d[c] = io_wdata;
                if (hit(io_addr, asc_pkg::A_STAT, c))
                begin
                    rie_d[c] = io_wdata[asc_pkg::ST_RIE];
                    tie_d[c] = io_wdata[asc_pkg::ST_TIE];
                end
                if (hit(io_addr, asc_pkg::A_TDR, c))
                begin
                    tdr_d[c]  = io_wdata;
                    tx_empty_flag_d[c] = 1'b0;
                end
            end
            if (io_rd)
            begin
                if (hit(io_addr, asc_pkg::A_CTLA, c))
                begin
                    r8 = ctla_q[c];
                    r8[asc_pkg::CA_EFR] = mpb_q[c];
                    rdata_d = r8;
                end
                if (hit(io_addr, asc_pkg::A_CTLB, c))
                begin
                    r8 = ctlb_q[c];
                    r8[asc_pkg::CB_PS] = cts_s[c];
                    rdata_d = r8;
                end
                if (hit(io_addr, asc_pkg::A_STAT, c))
                begin
                    r8 = 8'h00;
                    r8[asc_pkg::ST_RX_FULL_FLAG] = rx_full_flag_q[c];
                    r8[asc_pkg::ST_OVRN] = ovrn_q[c];
                    r8[asc_pkg::ST_PE]   = pe_q[c];
                    r8[asc_pkg::ST_FE]   = fe_q[c];
                    r8[asc_pkg::ST_RIE]  = rie_q[c];
                    r8[asc_pkg::ST_DCD]  = (c == 0) & dcd_q;
                    r8[asc_pkg::ST_TX_EMPTY_FLAG] = tx_empty_flag_v[c];
                    r8[asc_pkg::ST_TIE]  = tie_q[c];
                    rdata_d = r8;
                end
                if (hit(io_addr, asc_pkg::A_TDR, c))
                    rdata_d = tdr_q[c];
                if (hit(io_addr, asc_pkg::A_RDR, c))
                    rdata_d = rdr_q[c];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctla_q  <= '{default: asc_pkg::CTLA_RST};
            ctlb_q  <= '{default: asc_pkg::CTLB_RST};
            tdr_q   <= '{default: '0};
            rdr_q   <= '{default: '0};
            bcnt_q  <= '{default: '0};
            txsh_q  <= '{default: '0};
            rxsh_q  <= '{default: '0};
            txn_q   <= '{default: '0};
            rxn_q   <= '{default: '0};
            txs_q   <= '{default: '0};
            rxs_q   <= '{default: '0};
            tx_empty_flag_q  <= asc_pkg::TX_EMPTY_FLAG_RST;
            {rx_full_flag_q, ovrn_q, pe_q, fe_q, mpb_q, rie_q, tie_q, rxon_q, irq_q} <= '0;
            txd_q   <= '1;
            ext_p_q <= '0;
            dcd_q   <= 1'b0;
            rdata_q <= 8'h00;
            rts_q   <= asc_pkg::CTLA_RST[asc_pkg::CA_RTS];
        end
        else
        begin
            ctla_q  <= ctla_d;
            ctlb_q  <= ctlb_d;
            tdr_q   <= tdr_d;
            rdr_q   <= rdr_d;
            bcnt_q  <= bcnt_d;
            txsh_q  <= txsh_d;
            rxsh_q  <= rxsh_d;
            txn_q   <= txn_d;
            rxn_q   <= rxn_d;
            txs_q   <= txs_d;
            rxs_q   <= rxs_d;
            {tx_empty_flag_q, rx_full_flag_q, ovrn_q} <= {tx_empty_flag_d, rx_full_flag_d, ovrn_d};
            {pe_q, fe_q, mpb_q, rie_q, tie_q, rxon_q} <= {pe_d, fe_d, mpb_d, rie_d, tie_d, rxon_d};
            irq_q   <= irq_d;
            txd_q   <= txd_d;
            ext_p_q <= ext_s;
            dcd_q   <= dcd_d;
            rdata_q <= rdata_d;
            rts_q   <= ctla_q[0][asc_pkg::CA_RTS];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_load0;
        load[0] && !(io_wr && hit(io_addr, asc_pkg::A_TDR, 0));
    endsequence
    sequence s_quiet0;
        !io_wr && !io_rd;
    endsequence

    a_cts_masks_irq: assert property ((cts_s[0] && !rie_q[0]) |=> !irq_q[0])
        else $error("tx empty request while clear-to-send high");
    a_tie_irq_on: assert property ((tie_q[0] && tx_empty_flag_q[0] && !cts_s[0]) |=> irq_q[0])
        else $error("tx empty request missing");
    a_tx_shifts_cts: assert property ((cts_s[0] && txn_q[0] > 4'h1 && tick[0]
        && txs_q[0] == 7'h0f && !ctlb_q[0][asc_pkg::CB_DR] && ctla_q[0][asc_pkg::CA_TE])
        |=> txn_q[0] == $past(txn_q[0]) - 4'h1)
        else $error("shifter stalled");
    a_load_sets_tx_empty_flag: assert property (s_load0 |=> tx_empty_flag_q[0] ##1 tx_empty_flag_q[0] || !io_wr)
        else $error("empty flag not set on load");
    a_tdr_write_clr: assert property ((io_wr && hit(io_addr, asc_pkg::A_TDR, 0))
        |=> !tx_empty_flag_q[0] && tdr_q[0] == $past(io_wdata))
        else $error("empty flag not cleared on write");
    a_rdr_read_clr: assert property ((io_rd && hit(io_addr, asc_pkg::A_RDR, 0) && !done[0])
        |=> !rx_full_flag_q[0])
        else $error("full flag not cleared on read");
    a_efr_clears: assert property ((io_wr && hit(io_addr, asc_pkg::A_CTLA, 0)
        && !io_wdata[asc_pkg::CA_EFR] && !done[0]) |=> !(ovrn_q[0] | pe_q[0] | fe_q[0]))
        else $error("error flags not cleared");
    a_drop_no_effect: assert property ((drop[1] ##0 s_quiet0)
        |=> $stable({rx_full_flag_q[1], ovrn_q[1], pe_q[1], fe_q[1], rdr_q[1]}))
        else $error("dropped character changed flags");
    a_dcd_holds: assert property ((dcd_q && !dcd_s && !io_rd) |=> dcd_q)
        else $error("carrier bit cleared without status read");
    a_dcd_rx_reset: assert property (dcd_s |=> !rxon_q[0] && !rx_full_flag_q[0])
        else $error("receiver not held in reset");
    a_dcd_irq: assert property ((dcd_q && rie_q[0]) |=> irq_q[0])
        else $error("carrier request missing");
endmodule : asc_pair
`default_nettype wire

// ===== verification/asc_peer.sv
`default_nettype none
module asc_peer #(
    parameter int BIT_CYC = 160
) (
    input  wire logic core_clk,
    input  wire logic txd_line,
    output var logic  rxd_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rxd_line = 1'b1;

    // one bit cell, changed only just after a rising edge
    task automatic bit_out(input logic b);
        @(posedge core_clk);
        rxd_line <= b;
        repeat (BIT_CYC - 1) @(posedge core_clk);
    endtask : bit_out

    // start, data lsb first, optional extra bit, one stop; line left idle high
    task automatic send(input logic [7:0] data, input int nbits, input logic xon,
                        input logic xval);
        bit_out(1'b0);
        for (int i = 0; i < nbits; i++) bit_out(data[i]);
        if (xon) bit_out(xval);
        bit_out(1'b1);
    endtask : send

    // samples mid-bit; returns unknown on timeout or bad stop
    task automatic recv(input int nbits, output logic [8:0] val);
        int n;
        val = 'x;
        n = 0;
        // sampled on the falling edge, where the registered line has settled
        while (txd_line !== 1'b0 && n < 20000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 20000) return;
        repeat (BIT_CYC / 2) @(negedge core_clk);
        val = '0;
        for (int i = 0; i < nbits; i++)
        begin
            repeat (BIT_CYC) @(negedge core_clk);
            val[i] = txd_line;
        end
        repeat (BIT_CYC) @(negedge core_clk);
        if (txd_line !== 1'b1) val = 'x;
    endtask : recv
endmodule : asc_peer
`default_nettype wire

// ===== verification/tb_async_serial_channel_pair.sv
`default_nettype none
module tb_async_serial_channel_pair;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ca0 = asc_pkg::A_CTLA;
    localparam logic [7:0] ca1 = asc_pkg::A_CTLA + 8'h01;
    localparam logic [7:0] st0 = asc_pkg::A_STAT;
    localparam logic [7:0] st1 = asc_pkg::A_STAT + 8'h01;
    localparam logic [7:0] rd1 = asc_pkg::A_RDR + 8'h01;
    localparam int         limit = 40000;

    logic       core_clk;
    logic       nrst;
    logic [7:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    wire  logic [1:0] rxd;
    logic [1:0] cts_n;
    logic [1:0] ext_clk;
    logic       carrier_detect_in;
    logic [1:0] txd;
    logic       rts_n;
    logic [1:0] irq;
    logic [3:0] ext_cnt;
    int         num_errors;
    int         comparisons;
    int         cycles;

    asc_pair dut (.core_clk(core_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .rxd(rxd),
        .cts_n(cts_n), .ext_clk(ext_clk), .carrier_detect_in(carrier_detect_in),
        .txd(txd), .rts_n(rts_n), .irq(irq));
    asc_peer p0 (.core_clk(core_clk), .txd_line(txd[0]), .rxd_line(rxd[0]));
    asc_peer p1 (.core_clk(core_clk), .txd_line(txd[1]), .rxd_line(rxd[1]));

    always #2 core_clk = ~core_clk;

    // external tick every 10 cycles, same bit time as the internal divider
    always @(posedge core_clk)
    begin
        ext_cnt <= (ext_cnt == 4'h9) ? 4'h0 : ext_cnt + 4'h1;
        ext_clk <= {2{ext_cnt < 4'h5}};
    end

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == limit)
        begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_wr    <= 1'b1;
        io_addr  <= a;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        io_rd   <= 1'b1;
        io_addr <= a;
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1 d = io_rdata;
    endtask : rd

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(what, {1'b0, e}, {1'b0, d & m});
    endtask : rchk

    task automatic wait_bit(input logic [7:0] a, input int b);
        logic [7:0] d;
        d = '0;
        for (int n = 0; n < 3000 && d[b] !== 1'b1; n++) rd(a, d);
    endtask : wait_bit

    // pins pass a 2-flop synchroniser before the flags see them
    task automatic settle();
        repeat (5) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic t_reset();
        rchk("ctla0", ca0, 8'hff, asc_pkg::CTLA_RST);
        rchk("ctlb1", asc_pkg::A_CTLB + 8'h01, 8'hff, asc_pkg::CTLB_RST);
        rchk("channel_status", st0, 8'hff, 8'h02);
        rchk("stat1", st1, 8'hff, 8'h02);
        rchk("unmapped", 8'h0a, 8'hff, 8'h00);
        chk("txd idle", 9'h003, {7'h0, txd});
        chk("irq idle", 9'h000, {7'h0, irq});
    endtask : t_reset

    task automatic t_tx();
        logic [8:0] a;
        logic [8:0] b;
        wr(ca0, 8'h64);
        wr(st0, 8'h01);
        settle();
        chk("rts_n", 9'h000, {8'h0, rts_n});
        chk("irq0 tx", 9'h001, {8'h0, irq[0]});
        fork
            begin
                p0.recv(8, a);
                p0.recv(8, b);
            end
            begin
                wr(asc_pkg::A_TDR, 8'h3c);
                wr(asc_pkg::A_TDR, 8'hc3);
                rchk("tx_empty_flag held", st0, 8'h02, 8'h00);
            end
        join
        chk("tx a", 9'h03c, a);
        chk("tx b", 9'h0c3, b);
        rchk("tx_empty_flag set", st0, 8'h02, 8'h02);
        @(posedge core_clk);
        cts_n <= 2'b01;
        settle();
        chk("irq0 cts", 9'h000, {8'h0, irq[0]});
        rchk("tx_empty_flag cts", st0, 8'h02, 8'h00);
        fork
            p0.recv(8, a);
            wr(asc_pkg::A_TDR, 8'h5a);
        join
        chk("tx cts", 9'h05a, a);
        @(posedge core_clk);
        cts_n <= 2'b00;
        settle();
        chk("irq0 back", 9'h001, {8'h0, irq[0]});
        wr(st0, 8'h00);
        settle();
        chk("irq0 mask", 9'h000, {8'h0, irq[0]});
    endtask : t_tx

    task automatic t_ch1();
        logic [8:0] a;
        wr(asc_pkg::A_CTLB + 8'h01, 8'hc7);
        wr(ca1, 8'h60);
        wr(st1, 8'h08);
        fork
            p1.recv(8, a);
            wr(asc_pkg::A_TDR + 8'h01, 8'h2a);
        join
        chk("tx mp", 9'h0aa, a);
        p1.send(8'h55, 7, 1'b1, 1'b1);
        wait_bit(st1, 7);
        chk("irq1 rx", 9'h001, {8'h0, irq[1]});
        rchk("rdr1", rd1, 8'h7f, 8'h55);
        rchk("rxfull1", st1, 8'h80, 8'h00);
        settle();
        chk("irq1 off", 9'h000, {8'h0, irq[1]});
        wr(ca1, 8'he0);
        p1.send(8'h11, 7, 1'b1, 1'b0);
        settle();
        rchk("filtered", st1, 8'hf0, 8'h00);
        p1.send(8'h33, 7, 1'b1, 1'b1);
        wait_bit(st1, 7);
        rchk("kept", rd1, 8'h7f, 8'h33);
    endtask : t_ch1

    task automatic t_err();
        // odd parity and two stop bits; the idle line supplies the second stop
        wr(asc_pkg::A_CTLB, 8'h10);
        wr(ca0, 8'h77);
        wr(st0, 8'h08);
        p0.send(8'h81, 8, 1'b1, 1'b0);
        wait_bit(st0, 7);
        rchk("parity", st0, 8'hf0, 8'ha0);
        rchk("rdr0", asc_pkg::A_RDR, 8'hff, 8'h81);
        settle();
        chk("irq0 err", 9'h001, {8'h0, irq[0]});
        chk("rts_n hi", 9'h001, {8'h0, rts_n});
        wr(ca0, 8'h77);
        rchk("err clr", st0, 8'hf0, 8'h00);
        settle();
        chk("irq0 clr", 9'h000, {8'h0, irq[0]});
    endtask : t_err

    task automatic t_carrier();
        @(posedge core_clk);
        carrier_detect_in <= 1'b1;
        settle();
        chk("irq0 dcd", 9'h001, {8'h0, irq[0]});
        rchk("dcd hi", st0, 8'h04, 8'h04);
        p0.send(8'h42, 8, 1'b1, 1'b0);
        settle();
        rchk("rx held", st0, 8'hf0, 8'h00);
        @(posedge core_clk);
        carrier_detect_in <= 1'b0;
        settle();
        rchk("dcd kept", st0, 8'h04, 8'h04);
        rchk("dcd read", st0, 8'h04, 8'h00);
        settle();
        chk("irq0 idle", 9'h000, {8'h0, irq[0]});
    endtask : t_carrier

    initial
    begin
        core_clk          = 1'b0;
        nrst              = 1'b0;
        io_addr           = '0;
        io_wr             = 1'b0;
        io_rd             = 1'b0;
        io_wdata          = '0;
        cts_n             = 2'b00;
        ext_clk           = 2'b00;
        ext_cnt           = 4'h0;
        carrier_detect_in = 1'b0;
        num_errors        = 0;
        comparisons       = 0;
        cycles            = 0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_tx();
        t_ch1();
        t_err();
        t_carrier();
        print_verdict();
    end
endmodule : tb_async_serial_channel_pair
`default_nettype wire
